// *** common/urx_map.vh ***
// Register offsets, field positions and timing constants for the UART receiver.
// Assumes a plain strobe-based register port with word-wide data.
`ifndef URX_MAP_VH
`define URX_MAP_VH

`define URX_ADDR_W        4
`define URX_DATA_W        16

// Register offsets
`define URX_OFF_CTRL      4'h0
`define URX_OFF_STATUS    4'h1
`define URX_OFF_DATA      4'h2
`define URX_OFF_BAUD      4'h3

// Control field positions
`define URX_CTL_UART_EN   0
`define URX_CTL_RX_EN     1
`define URX_CTL_NINE      2
`define URX_CTL_PAR_EN    3
`define URX_CTL_PAR_ODD   4
`define URX_CTL_STOP2     5
`define URX_CTL_RIE       6

// Status field positions
`define URX_ST_AVAIL      0
`define URX_ST_OVERRUN    1
`define URX_ST_NOISE      2
`define URX_ST_FRAME      3
`define URX_ST_PARITY     4
`define URX_ST_IDLE       5
`define URX_ST_NINTH      6

`define URX_CTRL_RST      7'h00
`define URX_BAUD_RST      8'h00

// Oversampling
`define URX_OVS           5'd16
`define URX_MID_A         4'h6
`define URX_MID_B         4'h7
`define URX_MID_C         4'h8
`define URX_LAST_TICK     4'hf

`endif

// *** design/urx_receiver.v ***
// UART receiver: 16x oversampled recovery, two-entry FIFO, status flags.
// Assumes a baud divider on the system clock and a plain register port.
`timescale 1ns/1ps
`include "urx_map.vh"

module urx_receiver #(
   parameter DIV_W = 8
) (
   input  wire                    i_mclk,
   input  wire                    i_arst_n,
   input  wire [`URX_ADDR_W-1:0]  i_addr,
   input  wire [`URX_DATA_W-1:0]  i_wdata,
   input  wire                    i_wr,
   input  wire                    i_rd,
   output reg  [`URX_DATA_W-1:0]  o_rdata,
   input  wire                    i_rx,
   output wire                    o_rx_claim,
   output reg                     o_irq
);

   localparam ST_HUNT  = 2'd0;
   localparam ST_START = 2'd1;
   localparam ST_DATA  = 2'd2;
   localparam ST_STOP  = 2'd3;

   reg  [6:0]        ctrl_reg;
   reg  [DIV_W-1:0]  baud_divider_reg;
   reg  [DIV_W-1:0]  div_cnt_reg;
   reg               tick_reg;
   reg               rx_s1_reg;
   reg               rx_s2_reg;
   reg               rx_prev_reg;
   reg  [1:0]        state_reg;
   reg  [3:0]        ph_reg;
   reg  [3:0]        bit_cnt_reg;
   reg  [2:0]        smp_reg;
   reg  [8:0]        receive_shift_register;
   reg               noise_frame_reg;
   reg               framing_error_flag_frame_reg;
   reg               stop_second_reg;
   reg               wait_high_reg;
   reg               idle_reg;
   reg  [11:0]       fifo_mem [0:1];
   reg               fifo_rp_reg;
   reg               fifo_wp_reg;
   reg  [1:0]        fifo_cnt_reg;
   reg               overrun_reg;
   reg               status_seen_reg;

   wire uart_enable             = ctrl_reg[`URX_CTL_UART_EN];
   wire receiver_enable         = ctrl_reg[`URX_CTL_RX_EN];
   wire nine_bit_select         = ctrl_reg[`URX_CTL_NINE];
   wire parity_enable           = ctrl_reg[`URX_CTL_PAR_EN];
   wire parity_odd_even_select  = ctrl_reg[`URX_CTL_PAR_ODD];
   wire stop_count_select       = ctrl_reg[`URX_CTL_STOP2];
   wire receive_interrupt_enable = ctrl_reg[`URX_CTL_RIE];
   wire active = uart_enable & receiver_enable;

   wire wr_ctrl   = i_wr && (i_addr == `URX_OFF_CTRL);
   wire wr_baud   = i_wr && (i_addr == `URX_OFF_BAUD);
   wire rd_status = i_rd && (i_addr == `URX_OFF_STATUS);
   wire rd_data   = i_rd && (i_addr == `URX_OFF_DATA);

   // Total data bits incl. parity, 8 or 9 by the nine-bit select
   wire [3:0] nbits = 4'h8 + {3'h0, nine_bit_select};
   wire       majority = (smp_reg[0] & smp_reg[1]) | (smp_reg[0] & smp_reg[2]) |
                         (smp_reg[1] & smp_reg[2]);
   wire       noisy = ~(smp_reg[0] == smp_reg[1] && smp_reg[1] == smp_reg[2]);
   wire       at_end = tick_reg && (ph_reg == `URX_LAST_TICK);

   // Frame-done controls
   reg        push;
   reg        frame_done;
   reg [8:0]  word_aligned;
   reg        par_bit;
   reg        par_err;
   integer    k;

   // Baud tick divider: one tick per 16th of a bit
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div_cnt_reg <= {DIV_W{1'b0}};
         tick_reg    <= 1'b0;
      end else if (!active || div_cnt_reg == baud_divider_reg) begin
         div_cnt_reg <= {DIV_W{1'b0}};
         tick_reg    <= active;
      end else begin
         div_cnt_reg <= div_cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
         tick_reg    <= 1'b0;
      end
   end

   // Pin synchroniser
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rx_s1_reg   <= 1'b1;
         rx_s2_reg   <= 1'b1;
         rx_prev_reg <= 1'b1;
      end else begin
         rx_s1_reg <= i_rx;
         rx_s2_reg <= rx_s1_reg;
         if (tick_reg)
            rx_prev_reg <= rx_s2_reg;
      end
   end

   assign o_rx_claim = active;

   // Word at frame end: the shifter fills from the top, so align right
   always @* begin
      word_aligned = receive_shift_register;
      if (!nine_bit_select)
         word_aligned = {1'b0, receive_shift_register[8:1]};
      par_bit = 1'b0;
      for (k = 0; k < 9; k = k + 1)
         if (k < nbits)
            par_bit = par_bit ^ word_aligned[k];
      par_err = parity_enable & (par_bit ^ parity_odd_even_select);
   end

   always @* begin
      frame_done = 1'b0;
      // Gated by active so a frame cannot finish in the cycle after a disable
      if (active && state_reg == ST_STOP && tick_reg && ph_reg == `URX_MID_C + 4'h1)
         frame_done = !stop_count_select || stop_second_reg;
      push = frame_done && (fifo_cnt_reg != 2'd2);
   end

   // Receive state machine
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg              <= ST_HUNT;
         ph_reg                 <= 4'h0;
         bit_cnt_reg            <= 4'h0;
         smp_reg                <= 3'h7;
         receive_shift_register <= 9'h000;
         noise_frame_reg        <= 1'b0;
         framing_error_flag_frame_reg         <= 1'b0;
         stop_second_reg        <= 1'b0;
         wait_high_reg          <= 1'b0;
         idle_reg               <= 1'b1;
      end else if (!active) begin
         state_reg       <= ST_HUNT;
         wait_high_reg   <= 1'b0;
         idle_reg        <= 1'b1;
      end else if (tick_reg) begin
         ph_reg <= ph_reg + 4'h1;
         if (ph_reg == `URX_MID_A || ph_reg == `URX_MID_B || ph_reg == `URX_MID_C)
            smp_reg <= {smp_reg[1:0], rx_s2_reg};
         case (state_reg)
         ST_HUNT: begin
            ph_reg <= 4'h0;
            if (wait_high_reg) begin
               if (rx_s2_reg)
                  wait_high_reg <= 1'b0;
            end else if (rx_prev_reg && !rx_s2_reg) begin
               state_reg       <= ST_START;
               ph_reg          <= 4'h1;
               idle_reg        <= 1'b0;
               noise_frame_reg <= 1'b0;
               framing_error_flag_frame_reg  <= 1'b0;
               stop_second_reg <= 1'b0;
            end
         end
         ST_START: begin
            if (ph_reg == `URX_MID_C + 4'h1) begin
               if (majority) begin
                  state_reg <= ST_HUNT; // False start
                  idle_reg  <= 1'b1;
               end else if (noisy) begin
                  noise_frame_reg <= 1'b1;
               end
            end
            if (ph_reg == `URX_LAST_TICK) begin
               state_reg   <= ST_DATA;
               bit_cnt_reg <= 4'h0;
            end
         end
         ST_DATA: begin
            if (ph_reg == `URX_MID_C + 4'h1) begin
               receive_shift_register <= {majority, receive_shift_register[8:1]};
               if (noisy)
                  noise_frame_reg <= 1'b1;
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (ph_reg == `URX_LAST_TICK && bit_cnt_reg == nbits)
               state_reg <= ST_STOP;
         end
         default: begin
            if (ph_reg == `URX_MID_C + 4'h1) begin
               if (!majority)
                  framing_error_flag_frame_reg <= 1'b1;
               if (noisy)
                  noise_frame_reg <= 1'b1;
               if (frame_done) begin
                  state_reg     <= ST_HUNT;
                  idle_reg      <= 1'b1;
                  wait_high_reg <= ~majority | framing_error_flag_frame_reg;
               end else begin
                  stop_second_reg <= 1'b1;
               end
            end
         end
         endcase
      end
   end

   // Receive FIFO, entries {par, frame, noise, ninth+data}
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         fifo_rp_reg  <= 1'b0;
         fifo_wp_reg  <= 1'b0;
         fifo_cnt_reg <= 2'd0;
         fifo_mem[0]  <= 12'h000;
         fifo_mem[1]  <= 12'h000;
      end else if (!uart_enable) begin
         fifo_rp_reg  <= 1'b0;
         fifo_wp_reg  <= 1'b0;
         fifo_cnt_reg <= 2'd0;
      end else begin
         if (push) begin
            // Break yields an all-zero word by shifting zeros
            fifo_mem[fifo_wp_reg] <= {par_err, framing_error_flag_frame_reg | ~majority,
                                      noise_frame_reg, word_aligned};
            fifo_wp_reg <= ~fifo_wp_reg;
         end
         if (rd_data && status_seen_reg && fifo_cnt_reg != 2'd0)
            fifo_rp_reg <= ~fifo_rp_reg;
         fifo_cnt_reg <= fifo_cnt_reg + {1'b0, push}
                         - {1'b0, rd_data && status_seen_reg && fifo_cnt_reg != 2'd0};
      end
   end

   // Overrun flag and status-then-data sequence; set wins over clear
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         overrun_reg     <= 1'b0;
         status_seen_reg <= 1'b0;
      end else if (!uart_enable) begin
         overrun_reg     <= 1'b0;
         status_seen_reg <= 1'b0;
      end else begin
         if (rd_status)
            status_seen_reg <= 1'b1;
         else if (rd_data)
            status_seen_reg <= 1'b0;
         if (frame_done && fifo_cnt_reg == 2'd2)
            overrun_reg <= 1'b1;
         else if (rd_data && status_seen_reg)
            overrun_reg <= 1'b0;
      end
   end

   // Interrupt pulse on FIFO load or overrun
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n)
         o_irq <= 1'b0;
      else
         o_irq <= receive_interrupt_enable & frame_done;
   end

   // Control and baud registers
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_reg         <= `URX_CTRL_RST;
         baud_divider_reg <= `URX_BAUD_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= i_wdata[6:0];
            if (!i_wdata[`URX_CTL_UART_EN])
               ctrl_reg[`URX_CTL_RX_EN] <= 1'b0;
         end
         if (wr_baud)
            baud_divider_reg <= i_wdata[DIV_W-1:0];
      end
   end

   // Readback; shift register has no address
   wire [11:0] head = fifo_mem[fifo_rp_reg];
   wire        avail = (fifo_cnt_reg != 2'd0);
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rdata <= {`URX_DATA_W{1'b0}};
      end else if (i_rd) begin
         if (i_addr == `URX_OFF_CTRL)
            o_rdata <= {9'h000, ctrl_reg};
         else if (i_addr == `URX_OFF_STATUS)
            o_rdata <= {9'h000, head[8] & avail, idle_reg, head[11] & avail,
                        head[10] & avail, head[9] & avail, overrun_reg, avail};
         else if (i_addr == `URX_OFF_DATA)
            o_rdata <= {8'h00, head[7:0]};
         else if (i_addr == `URX_OFF_BAUD)
            o_rdata <= {{(`URX_DATA_W-DIV_W){1'b0}}, baud_divider_reg};
         else
            o_rdata <= {`URX_DATA_W{1'b0}};
      end else begin
         o_rdata <= {`URX_DATA_W{1'b0}};
      end
   end

endmodule

// *** dv/test_uart_receiver_with_error_flags.sv ***
// Self-checking bench for the UART receiver.
// Assumes the line model and bound monitor are compiled with it.
`timescale 1ns/1ps
module test_uart_receiver_with_error_flags;
   localparam int BT = 32;
   logic        i_mclk;
   logic        i_arst_n;
   logic [3:0]  i_addr;
   logic [15:0] i_wdata;
   logic        i_wr;
   logic        i_rd;
   logic [15:0] o_rdata;
   logic        rx;
   logic        o_rx_claim;
   logic        o_irq;
   int          num_errors = 0;
   int          check_count = 0;
   int          irqs = 0;
   logic [7:0]  lf;
   logic [7:0]  w [3];
   logic [15:0] v;

   urx_receiver uut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx(rx),
      .o_rx_claim(o_rx_claim), .o_irq(o_irq));
   urx_line_model #(.BIT_CLKS(BT)) ln (.i_mclk(i_mclk), .o_line(rx));

   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      if (o_irq === 1'b1)
         irqs <= irqs + 1;
   end

   function automatic logic [7:0] nxt(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // Head-of-FIFO status with idle and avail set
   function automatic logic [15:0] st(input logic ov, fr, pe, n9);
      return {9'h000, n9, 1'b1, pe, fr, 1'b0, ov, 1'b1};
   endfunction
   function automatic logic parity_error_flag(input logic [7:0] b, input logic odd);
      return (^b) != odd;
   endfunction

   task automatic wrap_up;
      if (num_errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      // Let an edge pass so a following write never re-raises i_wr in this step
      @(posedge i_mclk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic pop(input logic [15:0] es, input logic [15:0] ed);
      rd(4'h1, v);
      chk("status", es, v);
      rd(4'h2, v);
      chk("data", ed, v);
   endtask

   initial begin
      repeat (100000) @(posedge i_mclk);
      num_errors++;
      wrap_up();
   end

   initial begin
      i_arst_n = 1'b0;
      i_addr = 4'h0;
      i_wdata = 16'h0000;
      i_wr = 1'b0;
      i_rd = 1'b0;
      lf = 8'h4c;
      repeat (2) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      @(posedge i_mclk);
      wr(4'h3, 16'h0001);
      wr(4'h0, 16'h0043);
      #1 chk("claim", 16'h0001, {15'h0000, o_rx_claim});
      for (int k = 0; k < 3; k++) begin
         lf = nxt(lf);
         w[k] = lf;
         ln.send({2'b00, lf}, 8, 2'b11);
      end
      chk("irqs", 16'h0003, irqs[15:0]);
      pop(st(1, 0, 0, 0), {8'h00, w[0]});
      pop(st(0, 0, 0, 0), {8'h00, w[1]});
      rd(4'h1, v);
      chk("status", 16'h0020, v);
      // Data read without a status read first must not pop
      rd(4'h2, v);
      ln.send({2'b00, 8'h5a}, 8, 2'b11);
      rd(4'h2, v);
      chk("data", 16'h005a, v);
      pop(st(0, 0, 0, 0), 16'h005a);
      rd(4'h9, v);
      chk("unmapped", 16'h0000, v);
      lf = nxt(lf);
      for (int m = 0; m < 2; m++) begin
         wr(4'h0, m ? 16'h005b : 16'h004b);
         ln.send({2'b00, lf}, 8, 2'b11);
         pop(st(0, 0, parity_error_flag(lf, m[0]), 0), {8'h00, lf});
      end
      wr(4'h0, 16'h0047);
      ln.send({2'b01, lf}, 9, 2'b11);
      pop(st(0, 0, 0, 1), {8'h00, lf});
      wr(4'h0, 16'h0063);
      ln.send({2'b00, lf}, 8, 2'b01);
      ln.rest(1'b1, 2 * BT);
      ln.send({2'b00, w[2]}, 8, 2'b11);
      pop(st(0, 1, 0, 0), {8'h00, lf});
      pop(st(0, 0, 0, 0), {8'h00, w[2]});
      // Long break: held low well past the frame
      ln.send(10'h000, 8, 2'b00);
      ln.rest(1'b0, 20 * BT);
      ln.rest(1'b1, 2 * BT);
      pop(st(0, 1, 0, 0), 16'h0000);
      rd(4'h1, v);
      chk("status", 16'h0020, v);
      ln.send({2'b00, lf}, 8, 2'b11);
      wr(4'h0, 16'h0042);
      #1 chk("claim", 16'h0000, {15'h0000, o_rx_claim});
      rd(4'h1, v);
      chk("status", 16'h0020, v);
      wrap_up();
   end
endmodule

// *** dv/urx_line_model.sv ***
// Far-end serial transmitter on the receive line.
// Assumes the bench calls its tasks right after a clock edge.
`timescale 1ns/1ps
module urx_line_model #(
   parameter int BIT_CLKS = 32
) (
   input  wire logic i_mclk,
   output logic      o_line
);
   initial o_line = 1'b1;
   task automatic rest(input logic lvl, input int n);
      o_line <= lvl;
      repeat (n) @(posedge i_mclk);
   endtask
   // Last stop level is left on the line; caller restores idle
   task automatic send(input logic [9:0] w, input int nb, input logic [1:0] stp);
      rest(1'b0, BIT_CLKS);
      for (int i = 0; i < nb; i++)
         rest(w[i], BIT_CLKS);
      rest(stp[0], BIT_CLKS);
      rest(stp[1], BIT_CLKS);
   endtask
endmodule

// *** dv/urx_monitor.sv ***
// Port checker for the UART receiver.
// Assumes single clock, async active-low reset.
`timescale 1ns/1ps
module urx_monitor (
   input wire logic        i_mclk,
   input wire logic        i_arst_n,
   input wire logic [3:0]  i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic        i_rx,
   input wire logic        o_rx_claim,
   input wire logic        o_irq
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   logic rie_reg;
   always @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n)
         rie_reg <= 1'b0;
      else if (i_wr && i_addr == 4'h0)
         rie_reg <= i_wdata[6];
   end
   sequence s_off;
      i_wr && i_addr == 4'h0 && !i_wdata[0];
   endsequence
   sequence s_st;
      i_rd && i_addr == 4'h1;
   endsequence
   property p_flush;
      s_off ##2 s_st |=> !o_rdata[0] && o_rdata[5];
   endproperty
   a_flush: assert property (p_flush) else $error("flags kept on disable");
   property p_drop;
      s_off |=> !o_rx_claim;
   endproperty
   a_drop: assert property (p_drop) else $error("pin kept on disable");
   property p_claim;
      $rose(o_rx_claim) |-> $past(i_wr && i_addr == 4'h0 && i_wdata[1]);
   endproperty
   a_claim: assert property (p_claim) else $error("pin claimed unasked");
   property p_unmap;
      i_rd && i_addr > 4'h3 |=> o_rdata == 16'h0000;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_quiet;
      !i_rd |=> o_rdata == 16'h0000;
   endproperty
   a_quiet: assert property (p_quiet) else $error("read data without read");
   property p_rie;
      o_irq |-> rie_reg || $past(rie_reg);
   endproperty
   a_rie: assert property (p_rie) else $error("irq while masked");
   property p_irqen;
      o_irq |-> $past(o_rx_claim);
   endproperty
   a_irqen: assert property (p_irqen) else $error("irq while off");
   property p_gap;
      o_irq |=> !o_irq [*8];
   endproperty
   a_gap: assert property (p_gap) else $error("irq too close");
endmodule
bind urx_receiver urx_monitor u_mon (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx(i_rx),
   .o_rx_claim(o_rx_claim), .o_irq(o_irq));
